// ### verif/flash_array_model.sv
/*
 Behavioural flash array at the far side of the controller: takes one byte
 per request pulse while the high-voltage enable is up, and counts requests.
 Assumes requests arrive registered in the clk_i domain.
*/
`timescale 1ns/1ps
module flash_array_model
    import flash_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Request side
    input wire array_req_t array_i,
    input wire logic hv_en_i
);
    int n_req;
    logic [15:0] page;
    logic [7:0] mem [64];

    // Only requested bytes change; the rest of the page stays untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            n_req <= 0;
            page <= 16'h0000;
        end else if (array_i.req && hv_en_i) begin
            n_req <= n_req + 1;
            page <= array_i.page_addr;
            mem[array_i.idx] <= array_i.data;
        end
    end
endmodule

// ### verif/tb_top.sv
/*
 Self-checking bench for the flash page erase-program controller.
 Assumes short erase and program counts set through the parameters.
*/
`timescale 1ns/1ps
module tb_top;
    import flash_ctrl_pkg::*;
    localparam int EC = 80;
    localparam int PC = 80;
    logic clk_i, rst_i, cyc, stb, we, irq, bod, sec, bst, ack, stall, hv_en, in_rom;
    logic bo, hvf;
    logic [7:0] adr, vec;
    logic [15:0] rd;
    logic [31:0] dat, dat_o;
    logic [15:0] fetch, start_addr;
    array_req_t arr;
    int n_fail = 0;
    int checks = 0;
    int base;

    flash_page_erase_program_ctrl #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC))
    u_flash_page_erase_program_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
        .irq_pending_i(irq), .brownout_pin_i(bo), .bod_enabled_i(bod),
        .hv_fault_i(hvf), .page_secured_i(sec), .boot_status_i(bst),
        .boot_vector_i(vec), .fetch_addr_i(fetch), .cpu_stall_o(stall),
        .array_o(arr), .hv_enable_o(hv_en), .start_addr_o(start_addr),
        .in_boot_rom_o(in_rom));

    flash_array_model u_flash_array_model (
        .clk_i(clk_i), .rst_i(rst_i), .array_i(arr), .hv_en_i(hv_en));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; read data taken at the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o[15:0];
        if (n >= 50) chk(16'hDEAD, 16'h0000);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        @(posedge clk_i);
        while (stall !== 1'b0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    task automatic t_boot();
        chk(start_addr, 16'h0000);
        wb(1'b0, 8'hF4, 8'h00);
        chk(rd, 16'h0000);
        fetch <= 16'hFF00;
        repeat (3) @(posedge clk_i);
        chk({15'h0, in_rom}, 16'h0001);
        fetch <= 16'hFEFF;
        repeat (3) @(posedge clk_i);
        chk({15'h0, in_rom}, 16'h0000);
        bst <= 1'b1;
        vec <= 8'h1F;
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(start_addr, 16'h1F00);
        wb(1'b0, 8'hF8, 8'h00);
        chk(rd, 16'h1F00);
        wb(1'b0, 8'hF4, 8'h00);
        chk(rd, 16'h031F);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0000);
    endtask

    task automatic t_program();
        int n;
        wb(1'b1, 8'hE4, 8'h00);
        wb(1'b1, 8'hE8, 8'hFE);
        wb(1'b1, 8'hEC, 8'h12);
        wb(1'b1, 8'hF0, 8'hA1);
        wb(1'b1, 8'hF0, 8'hA2);
        wb(1'b1, 8'hF0, 8'hA3);
        wb(1'b0, 8'hE8, 8'h00);
        chk(rd, 16'h00C1);
        wb(1'b0, 8'h10, 8'h00);
        chk(rd, 16'h0000);
        base = u_flash_array_model.n_req;
        wb(1'b1, 8'hE4, 8'h68);
        chk({15'h0, stall}, 16'h0001);
        wait_idle(n);
        chk({15'h0, 1'(n >= EC + PC - 2 && n <= EC + PC + 3)}, 16'h0001);
        chk(16'(u_flash_array_model.n_req - base), 16'h0006);
        chk(u_flash_array_model.page, 16'h12C0);
        chk({8'h0, u_flash_array_model.mem[62]}, 16'h00A1);
        chk({8'h0, u_flash_array_model.mem[63]}, 16'h00A2);
        chk({8'h0, u_flash_array_model.mem[0]}, 16'h00A3);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0000);
    endtask

    task automatic t_abort();
        int n;
        wb(1'b1, 8'hE4, 8'h00);
        wb(1'b1, 8'hF0, 8'h55);
        wb(1'b1, 8'hE4, 8'h68);
        repeat (30) @(posedge clk_i);
        irq <= 1'b1;
        wait_idle(n);
        irq <= 1'b0;
        chk({15'h0, 1'(n <= 8)}, 16'h0001);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0009);
        wb(1'b1, 8'hE4, 8'h00);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0000);
        base = u_flash_array_model.n_req;
        wb(1'b1, 8'hF0, 8'h66);
        wb(1'b1, 8'hE4, 8'h68);
        wait_idle(n);
        chk(16'(u_flash_array_model.n_req - base), 16'h0002);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0000);
    endtask

    task automatic t_guard();
        int n;
        wb(1'b1, 8'hE4, 8'h00);
        base = u_flash_array_model.n_req;
        wb(1'b1, 8'hE4, 8'h68);
        wait_idle(n);
        chk(16'(u_flash_array_model.n_req - base), 16'h0000);
        bod <= 1'b0;
        wb(1'b1, 8'hE4, 8'h68);
        wait_idle(n);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0008);
        bod <= 1'b1;
        sec <= 1'b1;
        wb(1'b1, 8'hE4, 8'h68);
        wait_idle(n);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd, 16'h0002);
        sec <= 1'b0;
    endtask

    task automatic t_faults();
        int n;
        wb(1'b1, 8'hE4, 8'h00);
        wb(1'b1, 8'hE4, 8'h68);
        repeat (20) @(posedge clk_i);
        bo <= 1'b1;
        hvf <= 1'b1;
        wait_idle(n);
        bo <= 1'b0;
        hvf <= 1'b0;
        chk({15'h0, 1'(n <= 8)}, 16'h0001);
        wb(1'b0, 8'hE4, 8'h00);
        chk(rd & 16'h000C, 16'h000C);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_sim();
    end

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, irq, sec, bst, bo, hvf} = 8'h0;
        bod = 1'b1;
        adr = 8'h00;
        vec = 8'h00;
        dat = 32'h0;
        fetch = 16'h0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_boot();
        t_program();
        t_abort();
        t_guard();
        t_faults();
        end_sim();
    end
endmodule

// ### verilog/boot_start_sel.sv
/*
 Reset start-address selection and boot ROM address decode.
 Assumes boot status and vector are stable flash-held values.
*/
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module boot_start_sel (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Boot elements
    input wire logic boot_status_i,
    input wire logic [7:0] boot_vector_i,
    // Fetch address decode
    input wire logic [15:0] fetch_addr_i,
    output logic [15:0] start_addr_o,
    output logic in_boot_rom_o
);
    logic captured;

    // Start address is caught once after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            captured <= 1'b0;
            start_addr_o <= 16'h0000;
        end else if (!captured) begin
            captured <= 1'b1;
            start_addr_o <= boot_status_i ? {boot_vector_i, `START_LOW_BYTE} : 16'h0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_boot_rom_o <= 1'b0;
        end else begin
            in_boot_rom_o <= fetch_addr_i >= `BOOT_ROM_BASE;
        end
    end
endmodule

// ### verilog/flash_ctrl_cfg.svh
/*
 Configuration macros for the flash page erase-program controller:
 register offsets, field positions, command codes, reset values, timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FLASH_CTRL_CFG_SVH
`define FLASH_CTRL_CFG_SVH

`define OFS_CMD_STATUS 8'hE4
`define OFS_ADDR_LOW 8'hE8
`define OFS_ADDR_HIGH 8'hEC
`define OFS_DATA_IN 8'hF0
`define OFS_BOOT_CFG 8'hF4
`define OFS_START_ADDR 8'hF8
`define CMD_LOAD 8'h00
`define CMD_ERASE_PROGRAM 8'h68
`define BIT_OP_INT 0
`define BIT_SEC_VIOL 1
`define BIT_HV_ERR 2
`define BIT_HV_ABORT 3
`define STATUS_RESET 4'h0
`define ADDR_RESET 8'h00
`define CLK_MHZ 200
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000
`define PAGE_BYTES 64
`define BOOT_ROM_BASE 16'hFF00
`define BOOT_ROM_LAST 16'hFFFF
`define LOADER_BYTES 512
`define USER_CODE_END 16'h1FFF
`define START_LOW_BYTE 8'h00

`endif

// ### verilog/flash_ctrl_pkg.sv
/*
 Types shared by the flash page erase-program controller.
 Assumes flash_ctrl_cfg.svh is on the include path.
*/
package flash_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROGRAM = 2'b11,
        ST_FINISH = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic hv_abort;
        logic hv_error;
        logic sec_viol;
        logic op_int;
    } flash_status_t;

    typedef struct packed {
        logic req;
        logic [15:0] page_addr;
        logic [5:0] idx;
        logic [7:0] data;
    } array_req_t;
endpackage

// ### verilog/flash_page_erase_program_ctrl.sv
/*
 Flash page erase-program controller with Wishbone register slave.
 Assumes a flash array port that accepts one byte per cycle and
 interrupt, brown-out and security inputs already in the clk_i domain,
 except pin-level abort inputs which are synchronised here.
*/
`timescale 1ns/1ps
`include "flash_ctrl_cfg.svh"
module flash_page_erase_program_ctrl
    import flash_ctrl_pkg::*;
#(
    parameter int ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ,
    parameter int PROG_CYCLES = `PROG_TIME_US * `CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // System events
    input wire logic irq_pending_i,
    input wire logic brownout_pin_i,
    input wire logic bod_enabled_i,
    input wire logic hv_fault_i,
    input wire logic page_secured_i,
    // Boot elements and fetch
    input wire logic boot_status_i,
    input wire logic [7:0] boot_vector_i,
    input wire logic [15:0] fetch_addr_i,
    // CPU and array
    output logic cpu_stall_o,
    output array_req_t array_o,
    output logic hv_enable_o,
    output logic [15:0] start_addr_o,
    output logic in_boot_rom_o
);
    localparam int CW = $clog2(ERASE_CYCLES + PROG_CYCLES + 1);
    // First address of the serial loader window at the top of user code
    localparam logic [15:0] LOADER_BASE = 16'(`USER_CODE_END - `LOADER_BYTES + 1);

    typedef struct packed {
        seq_state_t st;
        logic [CW-1:0] cnt;
        logic [7:0] addr_low;
        logic [7:0] addr_high;
        flash_status_t status;
        logic [5:0] prog_idx;
        logic prog_valid;
        logic scan_done;
        logic cpu_stall;
        logic hv_enable;
        array_req_t arr;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] bo_sync;
    } ctrl_state_t;

    ctrl_state_t r, next_r;
    logic [7:0] pb_rdata;
    logic pb_rflag;
    logic pb_clear;
    logic pb_wr;
    logic [15:0] boot_start;
    logic boot_rom_hit;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    wire logic req = cyc_i && stb_i && !r.ack;
    wire logic wr0 = req && we_i && sel_i[0];
    wire logic busy = r.st != ST_IDLE;
    wire logic abort_ev = irq_pending_i || r.bo_sync[1];
    wire logic loader_hit = boot_start >= LOADER_BASE && boot_start <= `USER_CODE_END;

    page_buffer_mem #(.DEPTH(`PAGE_BYTES), .AW(6)) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(pb_clear),
        .wr_i(pb_wr),
        .waddr_i(r.addr_low[5:0]),
        .wdata_i(dat_i[7:0]),
        .raddr_i(r.prog_idx),
        .rdata_o(pb_rdata),
        .rflag_o(pb_rflag)
    );

    boot_start_sel u_boot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .boot_status_i(boot_status_i),
        .boot_vector_i(boot_vector_i),
        .fetch_addr_i(fetch_addr_i),
        .start_addr_o(boot_start),
        .in_boot_rom_o(boot_rom_hit)
    );

    always_comb begin
        next_r = r;
        pb_clear = 1'b0;
        pb_wr = 1'b0;
        next_r.bo_sync = {r.bo_sync[0], brownout_pin_i};
        next_r.ack = req;
        next_r.rdata = 32'h0000_0000;
        next_r.arr.req = 1'b0;
        if (req && !we_i) begin
            unique case (1'b1)
                // Upper 28 bits are always zero
                hit(adr_i, `OFS_CMD_STATUS): next_r.rdata = {28'h0, r.status};
                hit(adr_i, `OFS_ADDR_LOW): next_r.rdata = {24'h0, r.addr_low};
                hit(adr_i, `OFS_ADDR_HIGH): next_r.rdata = {24'h0, r.addr_high};
                // Bit 9 tells firmware that reset lands in the loader
                hit(adr_i, `OFS_BOOT_CFG): next_r.rdata = {22'h0, loader_hit, boot_status_i,
                    boot_vector_i};
                hit(adr_i, `OFS_START_ADDR): next_r.rdata = {16'h0, boot_start};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
        if (wr0 && !busy) begin
            if (hit(adr_i, `OFS_ADDR_LOW)) begin
                next_r.addr_low = dat_i[7:0];
            end else if (hit(adr_i, `OFS_ADDR_HIGH)) begin
                next_r.addr_high = dat_i[7:0];
            end else if (hit(adr_i, `OFS_DATA_IN)) begin
                pb_wr = 1'b1;
                // Wrap in the low six bits only
                next_r.addr_low = {r.addr_low[7:6], 6'(r.addr_low[5:0] + 6'h01)};
            end else if (hit(adr_i, `OFS_CMD_STATUS)) begin
                next_r.status = '0;
                if (dat_i[7:0] == `CMD_LOAD) begin
                    pb_clear = 1'b1;
                end else if (dat_i[7:0] == `CMD_ERASE_PROGRAM) begin
                    if (page_secured_i) begin
                        next_r.status.sec_viol = 1'b1;
                    end else if (!bod_enabled_i) begin
                        next_r.status.hv_abort = 1'b1;
                    end else begin
                        next_r.st = ST_ERASE;
                        next_r.cnt = '0;
                        next_r.cpu_stall = 1'b1;
                        next_r.hv_enable = 1'b1;
                    end
                end
            end
        end
        unique case (r.st)
            ST_IDLE: begin
                next_r.prog_idx = '0;
                next_r.prog_valid = 1'b0;
                next_r.scan_done = 1'b0;
            end
            ST_ERASE, ST_PROGRAM: begin
                next_r.cnt = CW'(r.cnt + 1'b1);
                // Walk the buffer once per phase; only flagged bytes go out
                // Read data lag the address by one cycle, hence prog_idx - 1
                next_r.arr.req = pb_rflag && r.prog_valid;
                next_r.arr.idx = 6'(r.prog_idx - 6'h01);
                next_r.arr.data = pb_rdata;
                next_r.arr.page_addr = {r.addr_high, r.addr_low[7:6], 6'h00};
                next_r.prog_valid = !r.scan_done;
                if (!r.scan_done) begin
                    next_r.prog_idx = 6'(r.prog_idx + 6'h01);
                    next_r.scan_done = r.prog_idx == 6'h3F;
                end
                if (r.st == ST_ERASE && r.cnt == CW'(ERASE_CYCLES - 1)) begin
                    next_r.st = ST_PROGRAM;
                    next_r.prog_valid = 1'b0;
                    next_r.prog_idx = '0;
                    next_r.scan_done = 1'b0;
                end else if (r.st == ST_PROGRAM
                        && r.cnt == CW'(ERASE_CYCLES + PROG_CYCLES - 1)) begin
                    next_r.st = ST_FINISH;
                end
                if (abort_ev) begin
                    next_r.st = ST_FINISH;
                    next_r.status.op_int = 1'b1;
                    next_r.status.hv_abort = 1'b1;
                end
                if (hv_fault_i) begin
                    next_r.status.hv_error = 1'b1;
                end
            end
            ST_FINISH: begin
                next_r.st = ST_IDLE;
                next_r.cpu_stall = 1'b0;
                next_r.hv_enable = 1'b0;
            end
        endcase
    end

    // Any reset brings status to zero; a cycle cut short by reset is gone
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.addr_low <= `ADDR_RESET;
            r.addr_high <= `ADDR_RESET;
            r.status <= `STATUS_RESET;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_addr_o <= 16'h0000;
            in_boot_rom_o <= 1'b0;
        end else begin
            start_addr_o <= boot_start;
            in_boot_rom_o <= boot_rom_hit;
        end
    end

    assign dat_o = r.rdata;
    assign ack_o = r.ack;
    assign cpu_stall_o = r.cpu_stall;
    assign array_o = r.arr;
    assign hv_enable_o = r.hv_enable;

    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_CMD_STATUS) && dat_i[7:0] == `CMD_ERASE_PROGRAM
            && !page_secured_i && bod_enabled_i) |=> cpu_stall_o;
    endproperty
    a_start: assert property (p_start) else $error("stall not raised");

    property p_exit;
        @(posedge clk_i) disable iff (rst_i)
        (r.st == ST_FINISH) |=> !cpu_stall_o && r.st == ST_IDLE;
    endproperty
    a_exit: assert property (p_exit) else $error("stall not released");

    property p_abort;
        @(posedge clk_i) disable iff (rst_i)
        ((r.st == ST_ERASE || r.st == ST_PROGRAM) && irq_pending_i)
            |=> r.status.op_int && r.status.hv_abort ##1 !cpu_stall_o;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not flagged");

    property p_erase_len;
        @(posedge clk_i) disable iff (rst_i)
        ($rose(r.st == ST_PROGRAM)) |-> r.cnt == CW'(ERASE_CYCLES);
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

    property p_wrap;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_DATA_IN))
            |=> r.addr_low == {$past(r.addr_low[7:6]), 6'($past(r.addr_low[5:0]) + 6'h01)};
    endproperty
    a_wrap: assert property (p_wrap) else $error("address increment wrong");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_CMD_STATUS) && dat_i[7:0] == `CMD_LOAD)
            |=> r.status == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_secure;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_CMD_STATUS) && dat_i[7:0] == `CMD_ERASE_PROGRAM
            && page_secured_i) |=> r.status.sec_viol && !cpu_stall_o;
    endproperty
    a_secure: assert property (p_secure) else $error("violation not flagged");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[31:4] == 28'h0 || !$past(hit(adr_i, `OFS_CMD_STATUS));
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_bod;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_CMD_STATUS) && dat_i[7:0] == `CMD_ERASE_PROGRAM
            && !page_secured_i && !bod_enabled_i) |=> r.status.hv_abort;
    endproperty
    a_bod: assert property (p_bod) else $error("detector-off abort missing");

    sequence s_hv_flagged;
        r.status.hv_abort;
    endsequence

    sequence s_stall_free;
        !cpu_stall_o && !hv_enable_o;
    endsequence

    property p_brownout;
        @(posedge clk_i) disable iff (rst_i)
        ((r.st == ST_ERASE || r.st == ST_PROGRAM) && r.bo_sync[1])
            |=> s_hv_flagged ##1 s_stall_free;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out abort missing");

    property p_req_hv;
        @(posedge clk_i) disable iff (rst_i)
        array_o.req |-> hv_enable_o;
    endproperty
    a_req_hv: assert property (p_req_hv) else $error("array request without voltage");

    property p_status_read;
        @(posedge clk_i) disable iff (rst_i)
        (req && !we_i && hit(adr_i, `OFS_CMD_STATUS))
            |=> ack_o && dat_o == {28'h0, $past(r.status)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_load_clear;
        @(posedge clk_i) disable iff (rst_i)
        (wr0 && !busy && hit(adr_i, `OFS_CMD_STATUS) && dat_i[7:0] == `CMD_LOAD)
            |-> ##2 !pb_rflag;
    endproperty
    a_load_clear: assert property (p_load_clear) else $error("update flag survived load");
endmodule

// ### verilog/page_buffer_mem.sv
/*
 64-byte page buffer with one update flag per byte and registered read.
 Assumes single clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module page_buffer_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clear_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port
    input wire logic [AW-1:0] raddr_i,
    output logic [7:0] rdata_o,
    output logic rflag_o
);
    logic [7:0] mem [DEPTH];
    logic [DEPTH-1:0] flags;

    // Flags clear on load; contents stay, but unflagged bytes read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            flags <= '0;
        end else if (wr_i) begin
            flags[waddr_i] <= 1'b1;
        end
        rflag_o <= flags[raddr_i];
        rdata_o <= flags[raddr_i] ? mem[raddr_i] : 8'h00;
    end

    always_ff @(posedge clk_i) begin
        if (wr_i && !clear_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule
